// ### src/nsx_pkg.sv
package nsx_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int EXEC_TIME_NS = 40;
   localparam int EXEC_CYC = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Exception flag and mask positions
   localparam int EXC_INV = 0;
   localparam int EXC_DEN = 1;
   localparam int EXC_ZDV = 2;
   localparam int EXC_OVF = 3;
   localparam int EXC_UDF = 4;
   localparam int EXC_PRE = 5;
   // Control word fields and reset
   localparam int CW_PC_LSB = 8;
   localparam int CW_RC_LSB = 10;
   localparam int CW_IC = 12;
   localparam logic [15:0] CW_RESET = 16'h033f;
   localparam logic [2:0] TOP_RESET = 3'h0;
   localparam logic [31:0] REAL_ADDR_MASK = 32'h000f_ffff;
   localparam logic [14:0] EXP_ONES = 15'h7fff;
   localparam logic [79:0] NAN_DEFAULT = 80'hffff_c000_0000_0000_0000;
   localparam logic [63:0] INF_SIG = 64'h8000_0000_0000_0000;

   typedef enum logic [3:0] {
      OP_NOP, OP_PUSH, OP_POP, OP_ARITH, OP_COMPARE, OP_REMAINDER, OP_EXAMINE,
      OP_LOAD_CW, OP_CLEAR_EXC, OP_STORE_STATUS, OP_STORE_ENV, OP_SAVE_STATE
   } nsx_op_t;

   typedef enum logic [1:0] {CMP_GT, CMP_LT, CMP_EQ, CMP_UN} nsx_cmp_t;

   typedef struct packed {
      nsx_op_t op;           // Instruction class
      logic [2:0] st_idx;    // Top-relative register index
      logic [79:0] data;     // Push value or arithmetic result
      logic [5:0] exc;       // Exceptions found by the arithmetic core
      nsx_cmp_t cmp;         // Compare outcome
      logic [2:0] quot;      // Remainder quotient bits Q2..Q0
      logic [1:0] quot_rng;  // 0: Q0 only, 1: Q1..Q0, 2: all three
      logic rem_done;        // Remainder reduction complete
      logic [5:0] udf_shift; // Right shift for gradual underflow
      logic [31:0] insn_addr;
      logic [3:0] prefix_len;
      logic [31:0] oper_addr;
      logic has_oper;
      logic [10:0] opcode;
      logic prot_mode;       // Protected mode pointer format
      logic [15:0] ctrl;     // New control word
   } nsx_cmd_t;
endpackage

// ### src/nsx_top.sv
`timescale 1ns/1ps
`default_nettype none
module nsx_top (
   input wire logic ref_clk_i,               // 100 MHz clock
   input wire logic resetn_i,                // Async reset, active low
   input wire logic cmd_valid_i,             // Instruction strobe
   input wire nsx_pkg::nsx_cmd_t cmd_i,      // Instruction contents
   output logic busy_o,                      // Execution unit busy
   output logic error_o,                     // Unmasked error pending
   output logic [15:0] status_word_o,        // Live status word
   output logic [15:0] control_word_o,       // Live control word
   output logic [79:0] pop_data_o,           // Value read by a pop
   output logic pop_valid_o,                 // Pop data strobe
   output logic [31:0] insn_ptr_o,           // Captured instruction address
   output logic [31:0] oper_ptr_o,           // Captured operand address
   output logic [10:0] opcode_o,             // Opcode captured in real mode, zero in protected mode
   output logic [15:0] store_word_o,         // Status image for a store
   output logic store_valid_o                // Store strobe
);
   ////////////////////////////////////////////////////////////////////////////
   logic [79:0] regs_q [8];
   logic [7:0] tag_q;
   logic [2:0] top_q, top_d;
   logic [3:0] cc_q, cc_d;
   logic [5:0] exc_q, exc_d, exc_set;
   logic [15:0] cw_q, cw_d;
   logic busy_q, err_sum_q;
   logic [2:0] cnt_q;
   nsx_pkg::nsx_cmd_t pend_q;
   logic exec_cmd, start, done, bus_cmd, clr;
   logic wr_en, tag_set, tag_clr, pop_en;
   logic [2:0] wr_idx, tag_idx, phys;
   logic [79:0] wr_val, rd_val, top_val;
   logic [31:0] ip_full;

   // Masked default responses applied to a result before write-back
   function automatic logic [79:0] fix_result(input logic [79:0] v, input logic [5:0] e,
                                              input logic [5:0] m, input logic [5:0] sh);
      logic nan;
      nan = (v[78:64] == nsx_pkg::EXP_ONES) && (v[62:0] != 63'h0);
      fix_result = v;
      if (e[nsx_pkg::EXC_INV] && m[nsx_pkg::EXC_INV]) begin
         fix_result = nan ? v : nsx_pkg::NAN_DEFAULT;
      end else if ((e[nsx_pkg::EXC_OVF] && m[nsx_pkg::EXC_OVF]) ||
                   (e[nsx_pkg::EXC_ZDV] && m[nsx_pkg::EXC_ZDV])) begin
         fix_result = {v[79], nsx_pkg::EXP_ONES, nsx_pkg::INF_SIG};
      end else if (e[nsx_pkg::EXC_UDF] && m[nsx_pkg::EXC_UDF]) begin
         fix_result = {v[79], 15'h0000, v[63:0] >> sh};
      end
      // Denormal and inexact masked: value passes unchanged
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Issue: execution ops wait for an idle unit; store ops never look at busy
   assign exec_cmd = (cmd_i.op == nsx_pkg::OP_PUSH) || (cmd_i.op == nsx_pkg::OP_POP) ||
                     (cmd_i.op == nsx_pkg::OP_ARITH) || (cmd_i.op == nsx_pkg::OP_COMPARE) ||
                     (cmd_i.op == nsx_pkg::OP_REMAINDER) || (cmd_i.op == nsx_pkg::OP_EXAMINE);
   assign start = cmd_valid_i && exec_cmd && !busy_q;
   assign bus_cmd = cmd_valid_i && !exec_cmd;
   assign done = busy_q && (cnt_q == 3'h1);
   assign clr = bus_cmd && (cmd_i.op == nsx_pkg::OP_CLEAR_EXC);
   assign phys = top_q + pend_q.st_idx;
   assign top_val = regs_q[top_q];
   assign ip_full = cmd_i.insn_addr - {28'h0, cmd_i.prefix_len};

   // Execution completion: stack, condition codes and new exception flags
   always_comb begin
      top_d = top_q;
      cc_d = cc_q;
      exc_set = 6'h00;
      wr_en = 1'b0;
      wr_idx = top_q;
      wr_val = pend_q.data;
      tag_set = 1'b0;
      tag_clr = 1'b0;
      tag_idx = top_q;
      pop_en = 1'b0;
      rd_val = top_val;
      if (done) begin
         case (pend_q.op)
            nsx_pkg::OP_PUSH: begin
               top_d = top_q - 3'h1;
               exc_set = pend_q.exc;
               exc_set[nsx_pkg::EXC_INV] = pend_q.exc[nsx_pkg::EXC_INV] | tag_q[top_d];
               wr_en = 1'b1;
               wr_idx = top_d;
               wr_val = fix_result(pend_q.data, exc_set, cw_q[5:0], pend_q.udf_shift);
               tag_set = 1'b1;
               tag_idx = top_d;
            end
            nsx_pkg::OP_POP: begin
               exc_set[nsx_pkg::EXC_INV] = !tag_q[top_q];
               if (!tag_q[top_q] && cw_q[nsx_pkg::EXC_INV]) begin
                  rd_val = nsx_pkg::NAN_DEFAULT;
               end
               pop_en = 1'b1;
               tag_clr = 1'b1;
               top_d = top_q + 3'h1;
            end
            nsx_pkg::OP_ARITH: begin
               exc_set = pend_q.exc;
               wr_en = 1'b1;
               wr_idx = phys;
               wr_val = fix_result(pend_q.data, pend_q.exc, cw_q[5:0], pend_q.udf_shift);
               tag_set = 1'b1;
               tag_idx = phys;
            end
            nsx_pkg::OP_COMPARE: begin
               exc_set = pend_q.exc;
               if (!tag_q[top_q] || pend_q.cmp == nsx_pkg::CMP_UN) begin
                  exc_set[nsx_pkg::EXC_INV] = 1'b1;
                  {cc_d[3], cc_d[2], cc_d[0]} = 3'b111;
               end else begin
                  case (pend_q.cmp)
                     nsx_pkg::CMP_GT: {cc_d[3], cc_d[2], cc_d[0]} = 3'b000;
                     nsx_pkg::CMP_LT: {cc_d[3], cc_d[2], cc_d[0]} = 3'b001;
                     default: {cc_d[3], cc_d[2], cc_d[0]} = 3'b100;
                  endcase
               end
            end
            nsx_pkg::OP_REMAINDER: begin
               exc_set = pend_q.exc;
               if (pend_q.rem_done) begin
                  cc_d[2] = 1'b0;
                  cc_d[1] = pend_q.quot[0];
                  if (pend_q.quot_rng != 2'h0) begin
                     cc_d[3] = pend_q.quot[1];
                  end
                  if (pend_q.quot_rng == 2'h2) begin
                     cc_d[0] = pend_q.quot[2];
                  end
               end else begin
                  cc_d[2] = 1'b1;
               end
            end
            nsx_pkg::OP_EXAMINE: begin
               cc_d[1] = top_val[79];
               if (!tag_q[top_q]) begin
                  {cc_d[3], cc_d[2], cc_d[0]} = 3'b101;
               end else if (top_val[78:0] == 79'h0) begin
                  {cc_d[3], cc_d[2], cc_d[0]} = 3'b100;
               end else if (top_val[78:64] == nsx_pkg::EXP_ONES) begin
                  {cc_d[3], cc_d[2], cc_d[0]} = (top_val[62:0] == 63'h0) ? 3'b011 : 3'b001;
               end else if (top_val[78:64] == 15'h0000) begin
                  {cc_d[3], cc_d[2], cc_d[0]} = 3'b001;
               end else begin
                  {cc_d[3], cc_d[2], cc_d[0]} = top_val[63] ? 3'b010 : 3'b000;
               end
            end
            default: begin
               top_d = top_q;
            end
         endcase
      end
   end

   // Flags accumulate; a new event wins over a clear in the same cycle
   assign exc_d = (clr ? 6'h00 : exc_q) | exc_set;
   assign cw_d = (bus_cmd && cmd_i.op == nsx_pkg::OP_LOAD_CW) ? cmd_i.ctrl : cw_q;

   ////////////////////////////////////////////////////////////////////////////
   // Busy and execution timer
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy_q <= 1'b0;
         cnt_q <= 3'h0;
      end else if (start) begin
         busy_q <= 1'b1;
         cnt_q <= 3'(nsx_pkg::EXEC_CYC);
      end else if (busy_q) begin
         cnt_q <= cnt_q - 3'h1;
         busy_q <= !done;
      end
   end

   // Pending instruction held for the whole execution
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pend_q <= '0;
      end else if (start) begin
         pend_q <= cmd_i;
      end
   end

   // Register stack and tags; tags let examine and pop see empty slots
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < 8; i++) begin
            regs_q[i] <= 80'h0;
         end
         tag_q <= 8'h00;
         top_q <= nsx_pkg::TOP_RESET;
      end else begin
         if (wr_en) begin
            regs_q[wr_idx] <= wr_val;
         end
         if (tag_set) begin
            tag_q[tag_idx] <= 1'b1;
         end else if (tag_clr) begin
            tag_q[tag_idx] <= 1'b0;
         end
         top_q <= top_d;
      end
   end

   // Condition codes, flags, control word and error summary
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cc_q <= 4'h0;
         exc_q <= 6'h00;
         cw_q <= nsx_pkg::CW_RESET;
         err_sum_q <= 1'b0;
      end else begin
         cc_q <= cc_d;
         exc_q <= exc_d;
         cw_q <= cw_d;
         err_sum_q <= |(exc_d & ~cw_d[5:0]);
      end
   end

   // Pointer capture on each new execution instruction
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         insn_ptr_o <= 32'h0;
         oper_ptr_o <= 32'h0;
         opcode_o <= 11'h000;
      end else if (start) begin
         if (cmd_i.prot_mode) begin
            insn_ptr_o <= ip_full;
            oper_ptr_o <= cmd_i.has_oper ? cmd_i.oper_addr : 32'h0;
            opcode_o <= 11'h000;
         end else begin
            insn_ptr_o <= ip_full & nsx_pkg::REAL_ADDR_MASK;
            oper_ptr_o <= cmd_i.has_oper ? (cmd_i.oper_addr & nsx_pkg::REAL_ADDR_MASK) : 32'h0;
            opcode_o <= cmd_i.opcode;
         end
      end
   end

   // Pop data and store strobes
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pop_data_o <= 80'h0;
         pop_valid_o <= 1'b0;
         store_word_o <= 16'h0000;
         store_valid_o <= 1'b0;
      end else begin
         pop_valid_o <= pop_en;
         if (pop_en) begin
            pop_data_o <= rd_val;
         end
         store_valid_o <= bus_cmd && (cmd_i.op == nsx_pkg::OP_STORE_STATUS ||
                          cmd_i.op == nsx_pkg::OP_STORE_ENV || cmd_i.op == nsx_pkg::OP_SAVE_STATE);
         if (bus_cmd) begin
            store_word_o <= status_word_o;
         end
      end
   end

   // Outputs are flop bits; bit 6 reads as zero
   assign busy_o = busy_q;
   assign error_o = err_sum_q;
   assign status_word_o = {busy_q, top_q, cc_q[3], cc_q[2], cc_q[1], cc_q[0], err_sum_q, 1'b0,
                           exc_q};
   assign control_word_o = cw_q;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   a_busy_length: assert property (start |=> busy_o [*4] ##1 !busy_o)
      else $error("busy width wrong");
   a_store_nobusy: assert property (!busy_q && bus_cmd && !start |=> !busy_o)
      else $error("store raised busy");
   a_error_summary: assert property (err_sum_q == |(exc_q & ~cw_q[5:0]))
      else $error("error summary mismatch");
   a_top_field: assert property (status_word_o[14:12] == top_q)
      else $error("top field wrong");
   a_push_top: assert property (done && pend_q.op == nsx_pkg::OP_PUSH |=>
      top_q == $past(top_q) - 3'h1 && tag_q[top_q])
      else $error("push pointer wrong");
   a_pop_top: assert property (done && pend_q.op == nsx_pkg::OP_POP |=>
      pop_valid_o && top_q == $past(top_q) + 3'h1)
      else $error("pop pointer wrong");
   a_flags_sticky: assert property (!clr |=> (exc_q & $past(exc_q)) == $past(exc_q))
      else $error("flag lost");
   a_cmp_equal: assert property (done && pend_q.op == nsx_pkg::OP_COMPARE &&
      pend_q.cmp == nsx_pkg::CMP_EQ && tag_q[top_q] |=>
      status_word_o[11:8] == {1'b1, 1'b0, $past(cc_q[1]), 1'b0})
      else $error("compare codes wrong");
   a_ptr_real: assert property (start && !cmd_i.prot_mode |=>
      insn_ptr_o == (($past(cmd_i.insn_addr) - 32'($past(cmd_i.prefix_len)))
      & nsx_pkg::REAL_ADDR_MASK))
      else $error("instruction pointer wrong");

   c_push_done: cover property (done && pend_q.op == nsx_pkg::OP_PUSH);
   c_error_raised: cover property (!error_o ##1 error_o);
   c_clear_collide: cover property (clr && exc_set != 6'h00);
   c_store_busy: cover property (busy_q && store_valid_o);
endmodule // nsx_top
`default_nettype wire

// ### tb/nsx_host.sv
`timescale 1ns/1ps
`default_nettype none
module nsx_host (
   input wire logic ref_clk_i,       // Device clock
   input wire logic busy_i,          // Device busy
   input wire logic error_i,         // Device error pending
   output logic cmd_valid_o,         // Instruction strobe
   output var nsx_pkg::nsx_cmd_t cmd_o // Instruction contents
);
   // Idle bus at time zero
   initial begin
      cmd_valid_o = 1'b0;
      cmd_o = '0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One escape from a falling edge; res 0 sent, 1 trapped, 2 timed out
   task automatic issue(input nsx_pkg::nsx_cmd_t c, output int res, output int n);
      logic ex;
      ex = (c.op != nsx_pkg::OP_NOP) && (c.op <= nsx_pkg::OP_EXAMINE);
      res = 0;
      n = 0;
      // Start one edge late so back-to-back calls never move the strobe twice at once
      @(negedge ref_clk_i);
      if (ex && error_i) begin
         res = 1;
         return;
      end
      // Execution ops wait on busy; bounded so a stuck device cannot hang us
      while (ex && busy_i && n < 50) begin
         @(negedge ref_clk_i);
         n++;
      end
      if (n == 50) begin
         res = 2;
         return;
      end
      n = 0;
      cmd_o = c;
      cmd_valid_o = 1'b1;
      @(negedge ref_clk_i);
      cmd_valid_o = 1'b0;
      cmd_o = ~c; // Stale contents never look like the last request
      while (ex && busy_i && n < 50) begin
         n++;
         @(negedge ref_clk_i);
      end
      if (n == 50) res = 2;
   endtask
endmodule // nsx_host
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct {nsx_pkg::nsx_op_t op; nsx_pkg::nsx_cmp_t cmp; logic [2:0] q; logic [3:0] cc;} nsx_row_t;
   localparam logic [79:0] VA = 80'h4000_c000_0000_0000_0000;
   localparam logic [79:0] VB = 80'h3fff_8000_0000_0000_0000;
   localparam logic [79:0] VC = 80'hc001_a000_0000_0000_0000;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cmd_valid_i, busy_o, error_o, pop_valid_o, store_valid_o;
   nsx_pkg::nsx_cmd_t cmd_i, c;
   logic [15:0] status_word_o, control_word_o, store_word_o;
   logic [79:0] pop_data_o;
   logic [31:0] insn_ptr_o, oper_ptr_o;
   logic [10:0] opcode_o;
   int n_mismatch = 0;
   int checks = 0;
   int res, nb;
   // Codes rows: remainder sets the untouched bit first, compares must keep it;
   // examine sees the normal positive value on top
   nsx_row_t rows[8] = '{
      '{nsx_pkg::OP_REMAINDER, nsx_pkg::CMP_GT, 3'h5, 4'h3},
      '{nsx_pkg::OP_COMPARE, nsx_pkg::CMP_GT, 3'h0, 4'h2},
      '{nsx_pkg::OP_COMPARE, nsx_pkg::CMP_LT, 3'h0, 4'h3},
      '{nsx_pkg::OP_COMPARE, nsx_pkg::CMP_EQ, 3'h0, 4'ha},
      '{nsx_pkg::OP_COMPARE, nsx_pkg::CMP_UN, 3'h0, 4'hf},
      '{nsx_pkg::OP_REMAINDER, nsx_pkg::CMP_GT, 3'h2, 4'h8},
      '{nsx_pkg::OP_EXAMINE, nsx_pkg::CMP_GT, 3'h0, 4'h4},
      '{nsx_pkg::OP_COMPARE, nsx_pkg::CMP_GT, 3'h0, 4'h0}};

   // Free-running 100 MHz clock
   always #5 ref_clk_i = ~ref_clk_i;

   nsx_top dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
      .cmd_i(cmd_i), .busy_o(busy_o), .error_o(error_o), .status_word_o(status_word_o),
      .control_word_o(control_word_o), .pop_data_o(pop_data_o), .pop_valid_o(pop_valid_o),
      .insn_ptr_o(insn_ptr_o), .oper_ptr_o(oper_ptr_o), .opcode_o(opcode_o),
      .store_word_o(store_word_o), .store_valid_o(store_valid_o));
   nsx_host host (.ref_clk_i(ref_clk_i), .busy_i(busy_o), .error_i(error_o),
      .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));

   ////////////////////////////////////////////////////////////////////////////////
   // Compare and report helpers
   task automatic chk_w(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_d(input string what, input logic [79:0] exp, input logic [79:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      $display("counts: %0d checks, %0d mismatches", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   function automatic nsx_pkg::nsx_cmd_t mk(input nsx_pkg::nsx_op_t op, input logic [79:0] d);
      nsx_pkg::nsx_cmd_t r;
      r = '0;
      r.op = op;
      r.data = d;
      r.quot_rng = 2'h2;
      r.rem_done = 1'b1;
      return r;
   endfunction
   // Execution ops must hold busy for the fixed run length
   task automatic run(input nsx_pkg::nsx_cmd_t x);
      host.issue(x, res, nb);
      if (res == 2) begin
         n_mismatch++;
         close_out();
      end
      if (x.op != nsx_pkg::OP_NOP && x.op <= nsx_pkg::OP_EXAMINE) begin
         chk_w("busy cycles", nsx_pkg::EXEC_CYC, 32'(nb));
      end
   endtask
   // Reset is asynchronous, so values are checked while it is still held
   task automatic reset_check(input string name);
      resetn_i = 1'b0;
      repeat (8) @(negedge ref_clk_i);
      chk_w("status", 32'h0, 32'(status_word_o));
      chk_w("control", 32'h033f, 32'(control_word_o));
      chk_w("busy error", 32'h0, 32'({busy_o, error_o, pop_valid_o, store_valid_o}));
      resetn_i = 1'b1;
      @(negedge ref_clk_i);
      $display("test %s ended, %0d mismatches", name, n_mismatch);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      reset_check("reset");
      run(mk(nsx_pkg::OP_PUSH, VA));
      chk_w("top", 32'h7, 32'(status_word_o[14:12]));
      run(mk(nsx_pkg::OP_PUSH, VB));
      chk_w("top", 32'h6, 32'(status_word_o[14:12]));
      foreach (rows[i]) begin
         c = mk(rows[i].op, '0);
         c.st_idx = 3'h1;
         c.cmp = rows[i].cmp;
         c.quot = rows[i].q;
         run(c);
         chk_w("cond codes", 32'(rows[i].cc), 32'(status_word_o[11:8]));
      end
      $display("test codes ended, %0d mismatches", n_mismatch);
      // Masked flags accumulate on top of the invalid left by the unordered compare row,
      // then unmasking one must raise the error
      c = mk(nsx_pkg::OP_ARITH, VB);
      c.exc = 6'h04;
      run(c);
      c.exc = 6'h20;
      run(c);
      chk_w("flags", 32'h25, 32'(status_word_o[5:0]));
      chk_w("error", 32'h0, 32'({error_o, status_word_o[7]}));
      c = mk(nsx_pkg::OP_LOAD_CW, '0);
      c.ctrl = 16'h033b;
      run(c);
      @(negedge ref_clk_i);
      chk_w("control", 32'h033b, 32'(control_word_o));
      chk_w("error", 32'h3, 32'({error_o, status_word_o[7]}));
      // With an error pending the host must refuse to issue another execution op
      host.issue(mk(nsx_pkg::OP_POP, '0), res, nb);
      chk_w("trap", 32'h1, 32'(res));
      run(mk(nsx_pkg::OP_CLEAR_EXC, '0));
      @(negedge ref_clk_i);
      chk_w("flags error", 32'h0, 32'({error_o, status_word_o[7], status_word_o[5:0]}));
      c = mk(nsx_pkg::OP_LOAD_CW, '0);
      c.ctrl = 16'h1e3f;
      run(c);
      chk_w("control", 32'h1e3f, 32'(control_word_o));
      $display("test exceptions ended, %0d mismatches", n_mismatch);
      // A status store lands in mid-execution and must not disturb busy
      c = mk(nsx_pkg::OP_PUSH, VC);
      c.insn_addr = 32'h1234_5678;
      c.prefix_len = 4'h2;
      c.oper_addr = 32'habcd_ef01;
      c.has_oper = 1'b1;
      c.opcode = 11'h5a5;
      fork
         run(c);
         begin
            repeat (2) @(negedge ref_clk_i);
            host.issue(mk(nsx_pkg::OP_STORE_STATUS, '0), res, nb);
            chk_w("store strobe", 32'h1, 32'(store_valid_o));
            chk_w("store word", 32'he000, 32'(store_word_o));
         end
      join
      chk_w("insn ptr", 32'h0004_5676, insn_ptr_o);
      chk_w("oper ptr", 32'h000d_ef01, oper_ptr_o);
      chk_w("opcode", 32'h5a5, 32'(opcode_o));
      c = mk(nsx_pkg::OP_POP, '0);
      c.insn_addr = 32'h8000_0003;
      c.prefix_len = 4'h3;
      c.oper_addr = 32'h0000_1000;
      c.has_oper = 1'b1;
      c.prot_mode = 1'b1;
      run(c);
      chk_d("pop data", VC, pop_data_o);
      chk_w("pop strobe", 32'h1, 32'(pop_valid_o));
      chk_w("insn ptr", 32'h8000_0000, insn_ptr_o);
      chk_w("oper ptr", 32'h0000_1000, oper_ptr_o);
      chk_w("opcode", 32'h0, 32'(opcode_o));
      run(mk(nsx_pkg::OP_POP, '0));
      chk_d("pop data", VB, pop_data_o);
      run(mk(nsx_pkg::OP_POP, '0));
      chk_d("pop data", VA, pop_data_o);
      chk_w("top", 32'h0, 32'(status_word_o[14:12]));
      run(mk(nsx_pkg::OP_POP, '0));
      chk_d("pop data", nsx_pkg::NAN_DEFAULT, pop_data_o);
      chk_w("flags error", 32'h1, 32'({error_o, status_word_o[5:0]}));
      // Environment and state stores snapshot the idle status word
      host.issue(mk(nsx_pkg::OP_STORE_ENV, '0), res, nb);
      chk_w("store env", 32'h0001_1001, 32'({store_valid_o, store_word_o}));
      host.issue(mk(nsx_pkg::OP_SAVE_STATE, '0), res, nb);
      chk_w("save state", 32'h0001_1001, 32'({store_valid_o, store_word_o}));
      $display("test stack ended, %0d mismatches", n_mismatch);
      reset_check("second reset");
      close_out();
   end
endmodule // tb
`default_nettype wire
